// [verilog/sbsf_top.sv]
// SPI master bit-rate generator, status flags and APB register file.
// Assumes APB master on CLK_I; MISO and slave select are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// Function
// - prescale code n divides by n+1
// - prescaler runs from bus clock, feeds divider
// - rate code n divides by 2^(n+1)
// - rate divider output clocks master bits
// - bit rate register accessible any time
// - unused flag bits read zero, writes ignored
// - transfer end sets receive full flag
// - flag read then data read clears
// - transmit empty while buffer has room
// - flag read then data write clears
// - data write without armed read ignored
// - interrupt when empty flag and enable
// - buffer to shifter move sets empty
// - idle write reloads empty within two cycles
// - queued byte loads when shifting ends
// - nothing queued: flag stays, no load
// - master with select low sets fault
// - fault only when master, enabled, no output
// - fault read then control write clears
// - disable halts, empties buffers, keeps mode fault flag
// - master starts transfer when shifter free
// - unread receive byte keeps, new dropped
module sbsf_top #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [31:0] PRDATA_O,
    // SPI pins
    input wire logic MISO_I,
    input wire logic SS_N_I,
    output logic SCK_O,
    output logic MOSI_O,
    output logic SS_N_O,
    // CPU interrupt request
    output logic IRQ_O
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (SYNC_STAGES != 2)
    begin : g_bad_sync
        $error("SYNC_STAGES must be 2");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Half bit period in prescaled ticks, minus one
    function automatic logic [6:0] half_limit(input logic [2:0] code);
        logic [7:0] v;
        v = (8'h01 << code) - 8'h01;
        return v[6:0];
    endfunction : half_limit

    function automatic logic is_reg(input logic [7:0] a);
        return a == sbsf_pkg::OFF_CONTROL_ONE
            || a == sbsf_pkg::OFF_CONTROL_TWO
            || a == sbsf_pkg::OFF_BIT_RATE
            || a == sbsf_pkg::OFF_FLAGS
            || a == sbsf_pkg::OFF_DATA_PORT;
    endfunction : is_reg

    sbsf_pkg::sbsf_state_s s;
    sbsf_pkg::sbsf_state_s n;

    logic enable;
    logic master;
    logic fault_gate;
    logic busy;
    logic pre_tick;
    logic half_tick;
    logic done;
    logic acc;
    logic wr;
    logic rd;
    logic data_wr_ok;
    logic load;
    logic [7:0] flags;
    logic [7:0] rx_byte;
    logic fault_hit;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n = s;
        enable = s.ctl1[sbsf_pkg::BIT_SYSTEM_ENABLE];
        master = s.ctl1[sbsf_pkg::BIT_MASTER_SELECT];
        fault_gate = master
            && s.ctl2[sbsf_pkg::BIT_FAULT_DETECT]
            && !s.ctl1[sbsf_pkg::BIT_SELECT_OE];
        busy = s.st == sbsf_pkg::ST_SHIFT;
        fault_hit = enable && fault_gate && !s.ss_s;
        acc = PSEL_I && PENABLE_I && s.pready;
        wr = acc && PWRITE_I;
        rd = acc && !PWRITE_I;
        rx_byte = {s.shift[6:0], s.sample};

        // Synchronisers
        n.miso_m = MISO_I;
        n.miso_s = s.miso_m;
        n.ss_m = SS_N_I;
        n.ss_s = s.ss_m;

        // Prescaler on bus clock, feeding the rate divider
        pre_tick = s.pre_cnt
            == s.baud[sbsf_pkg::PRESCALE_MSB:sbsf_pkg::PRESCALE_LSB];
        half_tick = pre_tick
            && s.rate_cnt == half_limit(
                s.baud[sbsf_pkg::RATE_MSB:sbsf_pkg::RATE_LSB]);
        n.pre_cnt = pre_tick ? 3'h0 : s.pre_cnt + 3'h1;
        if (pre_tick)
        begin
            n.rate_cnt = half_tick ? 7'h00 : s.rate_cnt + 7'h01;
        end
        // Counters parked while idle so every byte starts on phase
        if (!busy)
        begin
            n.pre_cnt = 3'h0;
            n.rate_cnt = 7'h00;
        end

        // Shifter: mode 0, MSB first; rise samples, fall shifts
        done = busy && half_tick && s.edge_cnt == sbsf_pkg::LAST_EDGE;
        if (busy && half_tick)
        begin
            n.sck = !s.sck;
            n.edge_cnt = s.edge_cnt + 4'h1;
            if (!s.edge_cnt[0])
            begin
                n.sample = s.miso_s;
            end
            else
            begin
                n.shift = rx_byte;
                n.mosi = s.shift[6];
            end
        end
        if (done)
        begin
            n.st = sbsf_pkg::ST_IDLE;
            n.sck = 1'b0;
            n.ss_out_n = 1'b1;
            if (!s.rx_full)
            begin
                n.rx_buf = rx_byte;
            end
            n.rx_full = 1'b1;
        end

        // Start: shifter free and a byte queued
        load = !busy && s.tx_full && enable && master;
        if (load)
        begin
            n.st = sbsf_pkg::ST_SHIFT;
            n.shift = s.tx_buf;
            n.mosi = s.tx_buf[7];
            n.edge_cnt = 4'h0;
            n.sck = 1'b0;
            n.tx_full = 1'b0;
            n.ss_out_n = !(master
                && s.ctl2[sbsf_pkg::BIT_FAULT_DETECT]
                && s.ctl1[sbsf_pkg::BIT_SELECT_OE]);
        end

        // APB answer: one wait state, then ready
        flags = 8'h00;
        flags[sbsf_pkg::BIT_RX_FULL] = s.rx_full;
        flags[sbsf_pkg::BIT_TX_EMPTY] = !s.tx_full;
        flags[sbsf_pkg::BIT_MASTER_FAULT] = s.fault;
        n.pready = PSEL_I && PENABLE_I && !s.pready;
        n.pslverr = PSEL_I && PENABLE_I && !s.pready && !is_reg(PADDR_I);
        n.prdata = 32'h0000_0000;
        if (PSEL_I && PENABLE_I && !s.pready && !PWRITE_I)
        begin
            case (PADDR_I)
                sbsf_pkg::OFF_CONTROL_ONE: n.prdata[7:0] = s.ctl1;
                sbsf_pkg::OFF_CONTROL_TWO: n.prdata[7:0] = s.ctl2;
                sbsf_pkg::OFF_BIT_RATE: n.prdata[7:0] = s.baud;
                sbsf_pkg::OFF_FLAGS: n.prdata[7:0] = flags;
                sbsf_pkg::OFF_DATA_PORT: n.prdata[7:0] = s.rx_buf;
                default: n.prdata = 32'h0000_0000;
            endcase
        end

        // Flag reads arm the clears with the value software saw
        if (rd && PADDR_I == sbsf_pkg::OFF_FLAGS)
        begin
            n.rx_armed = s.prdata[sbsf_pkg::BIT_RX_FULL];
            n.tx_armed = s.prdata[sbsf_pkg::BIT_TX_EMPTY];
            n.fault_armed = s.prdata[sbsf_pkg::BIT_MASTER_FAULT];
        end
        if (rd && PADDR_I == sbsf_pkg::OFF_DATA_PORT)
        begin
            n.rx_armed = 1'b0;
            if (s.rx_armed && !done)
            begin
                n.rx_full = 1'b0;
            end
        end

        // Register writes
        data_wr_ok = wr && PADDR_I == sbsf_pkg::OFF_DATA_PORT
            && s.tx_armed && !s.tx_full;
        if (wr)
        begin
            case (PADDR_I)
                sbsf_pkg::OFF_CONTROL_ONE:
                begin
                    n.ctl1 = PWDATA_I[7:0];
                    if (s.fault_armed)
                    begin
                        n.fault = 1'b0;
                        n.fault_armed = 1'b0;
                    end
                end
                sbsf_pkg::OFF_CONTROL_TWO:
                    n.ctl2 = PWDATA_I[7:0] & sbsf_pkg::MASK_CONTROL_TWO;
                sbsf_pkg::OFF_BIT_RATE:
                    n.baud = PWDATA_I[7:0] & sbsf_pkg::MASK_BIT_RATE;
                sbsf_pkg::OFF_DATA_PORT:
                    n.tx_armed = 1'b0;
                default: n.tx_armed = s.tx_armed;
            endcase
        end
        if (data_wr_ok)
        begin
            n.tx_buf = PWDATA_I[7:0];
            n.tx_full = 1'b1;
        end

        // Mode fault: set wins over the clear above
        if (fault_hit)
        begin
            n.fault = 1'b1;
        end

        // Disable: halt and restore empty buffers
        if (!enable)
        begin
            n.st = sbsf_pkg::ST_IDLE;
            n.tx_full = 1'b0;
            n.rx_full = 1'b0;
            n.tx_armed = 1'b0;
            n.rx_armed = 1'b0;
            n.sck = 1'b0;
            n.ss_out_n = 1'b1;
            n.edge_cnt = 4'h0;
        end

        n.irq = !n.tx_full && n.ctl1[sbsf_pkg::BIT_TX_IRQ_ENABLE];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            s <= '0;
            s.ctl1 <= sbsf_pkg::RST_CONTROL_ONE;
            s.ctl2 <= sbsf_pkg::RST_CONTROL_TWO;
            s.baud <= sbsf_pkg::RST_BIT_RATE;
            s.miso_m <= 1'b0;
            s.ss_m <= 1'b1;
            s.ss_s <= 1'b1;
            s.ss_out_n <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign PREADY_O = s.pready;
    assign PSLVERR_O = s.pslverr;
    assign PRDATA_O = s.prdata;
    assign SCK_O = s.sck;
    assign MOSI_O = s.mosi;
    assign SS_N_O = s.ss_out_n;
    assign IRQ_O = s.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence s_idle_write;
        data_wr_ok && !busy && enable && master;
    endsequence

    // Armed data read, not beaten by a completing frame
    sequence s_rx_release;
        rd && PADDR_I == sbsf_pkg::OFF_DATA_PORT && s.rx_armed && !done;
    endsequence

    // Armed control write, not beaten by a fresh fault
    sequence s_fault_release;
        wr && PADDR_I == sbsf_pkg::OFF_CONTROL_ONE && s.fault_armed
            && !fault_hit;
    endsequence

    chk_flags_zero: assert property (
        rd && PADDR_I == sbsf_pkg::OFF_FLAGS |-> PRDATA_O[6] == 1'b0
            && PRDATA_O[3:0] == 4'h0)
        else $error("unused flag bits not zero");
    chk_baud_store: assert property (
        wr && PADDR_I == sbsf_pkg::OFF_BIT_RATE
            |=> s.baud == ($past(PWDATA_I[7:0]) & 8'h77))
        else $error("bit rate write lost");
    chk_rx_set: assert property (
        done && enable |=> s.rx_full && !busy)
        else $error("receive full not set");
    chk_rx_keep: assert property (
        done && s.rx_full |=> $stable(s.rx_buf))
        else $error("unread byte overwritten");
    chk_tx_ignore: assert property (
        wr && PADDR_I == sbsf_pkg::OFF_DATA_PORT && !s.tx_armed
            && !s.tx_full |=> !s.tx_full)
        else $error("unarmed data write taken");
    chk_idle_reload: assert property (
        s_idle_write |-> ##[1:2] (!s.tx_full && busy))
        else $error("idle byte not moved in two cycles");
    chk_irq_follow: assert property (
        IRQ_O == (!s.tx_full && s.ctl1[sbsf_pkg::BIT_TX_IRQ_ENABLE]))
        else $error("interrupt missing");
    chk_fault_gate: assert property (
        $rose(s.fault) |-> $past(fault_gate) && !$past(s.ss_s))
        else $error("fault set outside gate");
    chk_disable: assert property (
        !enable |=> !s.rx_full && !s.tx_full && !busy)
        else $error("disable did not clear");
    chk_half_period: assert property (
        busy && enable && !half_tick |=> $stable(s.sck))
        else $error("bit clock too fast");
    chk_rx_clear: assert property (
        s_rx_release |=> !s.rx_full)
        else $error("receive full not cleared");
    chk_rx_hold: assert property (
        s.rx_full && enable && !s.rx_armed |=> s.rx_full)
        else $error("receive full lost without read");
    chk_tx_take: assert property (
        data_wr_ok && enable |=> s.tx_full)
        else $error("armed data write lost");
    chk_load_empty: assert property (
        load |=> busy && !s.tx_full)
        else $error("load did not empty buffer");
    chk_no_load: assert property (
        done && !s.tx_full && !data_wr_ok |=> !s.tx_full && !busy)
        else $error("empty buffer loaded");
    chk_fault_set: assert property (
        fault_hit |=> s.fault)
        else $error("mode fault not set");
    chk_fault_clear: assert property (
        s_fault_release |=> !s.fault)
        else $error("mode fault not cleared");

endmodule : sbsf_top

`default_nettype wire

// [verilog/sbsf_pkg.sv]
// Constants, state types and register map of the SPI rate and flag block.
// Assumes a 32-bit APB slave port; each register one aligned word.
`default_nettype none

package sbsf_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFF_BIT_RATE = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_DATA_PORT = 8'h14;

    // ------------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------------
    localparam int BIT_SYSTEM_ENABLE = 6;
    localparam int BIT_TX_IRQ_ENABLE = 5;
    localparam int BIT_MASTER_SELECT = 4;
    localparam int BIT_SELECT_OE = 1;
    localparam int BIT_FAULT_DETECT = 4;
    localparam int BIT_RX_FULL = 7;
    localparam int BIT_TX_EMPTY = 5;
    localparam int BIT_MASTER_FAULT = 4;
    localparam int PRESCALE_MSB = 6;
    localparam int PRESCALE_LSB = 4;
    localparam int RATE_MSB = 2;
    localparam int RATE_LSB = 0;
    localparam logic [7:0] MASK_BIT_RATE = 8'h77;
    localparam logic [7:0] MASK_CONTROL_TWO = 8'h1B;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL_ONE = 8'h04;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RST_BIT_RATE = 8'h00;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam int IDLE_RELOAD_CYCLES = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01
    } sbsf_mode_e;

    typedef struct packed {
        sbsf_mode_e st;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] baud;
        logic [2:0] pre_cnt;
        logic [6:0] rate_cnt;
        logic [3:0] edge_cnt;
        logic [7:0] shift;
        logic sample;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] rx_buf;
        logic rx_full;
        logic fault;
        logic tx_armed;
        logic rx_armed;
        logic fault_armed;
        logic miso_m;
        logic miso_s;
        logic ss_m;
        logic ss_s;
        logic sck;
        logic mosi;
        logic ss_out_n;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sbsf_state_s;

endpackage : sbsf_pkg

`default_nettype wire

// [test/sbsf_slave.sv]
// Serial slave model for the rate and flag bench: mode 0, MSB first.
// Assumes the master drives a low select for each frame.
`timescale 1ns/1ps
`default_nettype none

module sbsf_slave (
    // Serial pins
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    output logic miso_o,
    // Bench side
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o
);
    logic [7:0] sh = 8'h00;

    always @(negedge ss_n_i) sh = tx_i;
    always @(posedge sck_i) rx_o = {rx_o[6:0], mosi_i};
    always @(negedge sck_i) if (!ss_n_i) sh = {sh[6:0], ~sh[7]};
    // Released line shows the inverse, so a stale bit never passes
    assign miso_o = ss_n_i ? ~sh[7] : sh[7];
endmodule : sbsf_slave

`default_nettype wire

// [test/sbsf_top_tb.sv]
// Self-checking bench for sbsf_top: rates, flags and APB access.
// Assumes the mode-0 slave model sits on the serial pins.
`timescale 1ns/1ps
`default_nettype none

module sbsf_top_tb;
    typedef struct packed {
        logic [2:0] p;
        logic [2:0] r;
        logic [7:0] tx;
        logic [7:0] rx;
    } sbsf_row_s;
    // Half periods of three cycles or more: MISO has two cycles of sync lag
    localparam sbsf_row_s ROWS [5] = '{
        '{3'h0, 3'h2, 8'hA5, 8'h3C}, '{3'h7, 3'h0, 8'h81, 8'h7E},
        '{3'h2, 3'h3, 8'h5A, 8'hC3}, '{3'h4, 3'h1, 8'h01, 8'hFE},
        '{3'h1, 3'h7, 8'hF0, 8'h0F}};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic ss_n = 1'b1;
    logic [7:0] addr = 8'h00, slv_tx = 8'h00, slv_rx;
    logic [31:0] wdat = 32'h0, q, rdata;
    logic err, ready, slverr, sck, mosi, ss_out_n, irq, miso;
    int n_errors = 0, checks = 0, n;

    sbsf_top u_sbsf_top (
        .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdat),
        .PREADY_O(ready), .PSLVERR_O(slverr), .PRDATA_O(rdata),
        .MISO_I(miso), .SS_N_I(ss_n), .SCK_O(sck), .MOSI_O(mosi),
        .SS_N_O(ss_out_n), .IRQ_O(irq));
    sbsf_slave u_sbsf_slave (.sck_i(sck), .mosi_i(mosi),
        .ss_n_i(ss_out_n), .miso_o(miso), .tx_i(slv_tx), .rx_o(slv_rx));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic bail;
        n_errors++;
        tally_and_finish;
    endtask : bail

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 20 && ready !== 1'b1; k++) @(posedge clk);
        if (ready !== 1'b1)
            bail;
        q = rdata;
        err = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wt(input bit ss, input logic v);
        int k;
        for (k = 0; k < 5000 && (ss ? ss_out_n : sck) !== v; k++)
            @(posedge clk);
        if (k == 5000)
            bail;
    endtask : wt

    task automatic flags(input logic [7:0] e);
        apb(1'b0, sbsf_pkg::OFF_FLAGS, 8'h00);
        cmp("flags", {24'h0, e}, q);
    endtask : flags

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, sbsf_pkg::OFF_CONTROL_ONE, 8'h00);
        cmp("ctl1", {24'h0, sbsf_pkg::RST_CONTROL_ONE}, q);
        cmp("irq", 32'h0, {31'h0, irq});
        flags(8'h20);
        apb(1'b1, sbsf_pkg::OFF_FLAGS, 8'hFF);
        flags(8'h20);
        apb(1'b1, 8'h10, 8'h55);
        apb(1'b0, 8'h10, 8'h00);
        cmp("slverr", 32'h1, {31'h0, err});
        cmp("rdata", 32'h0, q);
        apb(1'b1, sbsf_pkg::OFF_CONTROL_TWO, 8'h10);
        apb(1'b1, sbsf_pkg::OFF_CONTROL_ONE, 8'h52);
        foreach (ROWS[i])
        begin
            apb(1'b1, sbsf_pkg::OFF_BIT_RATE,
                {1'b1, ROWS[i].p, 1'b1, ROWS[i].r});
            slv_tx = ROWS[i].rx;
            flags(8'h20);
            apb(1'b1, sbsf_pkg::OFF_DATA_PORT, ROWS[i].tx);
            wt(1'b0, 1'b1);
            for (n = 0; n < 3000 && sck === 1'b1; n++) @(posedge clk);
            cmp("half", (32'(ROWS[i].p) + 1) << ROWS[i].r, n);
            apb(1'b0, sbsf_pkg::OFF_BIT_RATE, 8'h00);
            cmp("baud", {25'h0, ROWS[i].p, 1'b0, ROWS[i].r}, q);
            wt(1'b1, 1'b1);
            cmp("mosi", {24'h0, ROWS[i].tx}, {24'h0, slv_rx});
            flags(8'hA0);
            apb(1'b0, sbsf_pkg::OFF_DATA_PORT, 8'h00);
            cmp("rx", {24'h0, ROWS[i].rx}, q);
            flags(8'h20);
        end
        // Second write without a fresh flag read
        apb(1'b1, sbsf_pkg::OFF_BIT_RATE, 8'h02);
        flags(8'h20);
        apb(1'b1, sbsf_pkg::OFF_DATA_PORT, 8'hC5);
        apb(1'b1, sbsf_pkg::OFF_DATA_PORT, 8'h3A);
        wt(1'b1, 1'b1);
        repeat (40) @(posedge clk);
        cmp("mosi", 32'hC5, {24'h0, slv_rx});
        flags(8'hA0);
        // Disable in mid-frame
        apb(1'b1, sbsf_pkg::OFF_DATA_PORT, 8'h77);
        wt(1'b0, 1'b1);
        apb(1'b1, sbsf_pkg::OFF_CONTROL_ONE, 8'h12);
        repeat (40) @(posedge clk);
        cmp("sck", {31'h0, sck}, 32'h0);
        flags(8'h20);
        // Queued byte and overrun
        apb(1'b1, sbsf_pkg::OFF_CONTROL_ONE, 8'h72);
        flags(8'h20);
        cmp("irq", 32'h1, {31'h0, irq});
        slv_tx = 8'h69;
        apb(1'b1, sbsf_pkg::OFF_DATA_PORT, 8'hE1);
        flags(8'h20);
        apb(1'b1, sbsf_pkg::OFF_DATA_PORT, 8'h1E);
        flags(8'h00);
        cmp("irq", 32'h0, {31'h0, irq});
        wt(1'b1, 1'b1);
        slv_tx = 8'hB4;
        cmp("mosi", 32'hE1, {24'h0, slv_rx});
        wt(1'b1, 1'b0);
        wt(1'b1, 1'b1);
        cmp("mosi", 32'h1E, {24'h0, slv_rx});
        flags(8'hA0);
        apb(1'b0, sbsf_pkg::OFF_DATA_PORT, 8'h00);
        cmp("rx", 32'h69, q);
        flags(8'h20);
        // Mode fault
        ss_n <= 1'b0;
        repeat (8) @(posedge clk);
        flags(8'h20);
        apb(1'b1, sbsf_pkg::OFF_CONTROL_ONE, 8'h50);
        repeat (8) @(posedge clk);
        flags(8'h30);
        ss_n <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b1, sbsf_pkg::OFF_CONTROL_ONE, 8'h50);
        flags(8'h20);
        // Reset in mid-frame restores defaults
        apb(1'b1, sbsf_pkg::OFF_DATA_PORT, 8'h99);
        wt(1'b0, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("sck", 32'h0, {31'h0, sck});
        cmp("irq", 32'h0, {31'h0, irq});
        rst <= 1'b0;
        apb(1'b0, sbsf_pkg::OFF_BIT_RATE, 8'h00);
        cmp("baud", {24'h0, sbsf_pkg::RST_BIT_RATE}, q);
        flags(8'h20);
        tally_and_finish;
    end
endmodule : sbsf_top_tb

`default_nettype wire
